// ==== pkg/cbt_defs.svh ====
/*
 * constants of the bit and transfer execution core
 * assumes a word wide classic wishbone register port
 */
`ifndef CBT_DEFS_SVH
`define CBT_DEFS_SVH
// ****************
// register offsets
// ****************
`define CBT_ADR_INSN 8'h00
`define CBT_ADR_STAT 8'h04
`define CBT_ADR_SP   8'h08
`define CBT_ADR_GPR  8'h80
`define CBT_SP_RST   16'h00ff
// *****************
// instruction codes
// *****************
`define CBT_OP_NOP  6'h00
`define CBT_OP_IOS  6'h01
`define CBT_OP_IOC  6'h02
`define CBT_OP_SHUP 6'h03
`define CBT_OP_SHDN 6'h04
`define CBT_OP_ROTL 6'h05
`define CBT_OP_ROTR 6'h06
`define CBT_OP_SHSG 6'h07
`define CBT_OP_SWAP 6'h08
`define CBT_OP_FSET 6'h09
`define CBT_OP_FCLR 6'h0a
`define CBT_OP_TCAP 6'h0b
`define CBT_OP_TPUT 6'h0c
`define CBT_OP_COPY 6'h0d
`define CBT_OP_CPYW 6'h0e
`define CBT_OP_IMM  6'h0f
`define CBT_OP_LDX  6'h10
`define CBT_OP_STX  6'h11
`define CBT_OP_DRD  6'h12
`define CBT_OP_DWR  6'h13
`define CBT_OP_CODE 6'h14
`define CBT_OP_IN   6'h15
`define CBT_OP_OUT  6'h16
`define CBT_OP_PUSH 6'h17
`define CBT_OP_POP  6'h18
// ************************************
// pointer modes, pointers, flag places
// ************************************
`define CBT_PM_PLAIN 2'h0
`define CBT_PM_POST  2'h1
`define CBT_PM_PRE   2'h2
`define CBT_PM_DISP  2'h3
`define CBT_PTR_BASE 5'h1a
`define CBT_PTR_Z    5'h1e
`define CBT_F_C 3'h0
`define CBT_F_Z 3'h1
`define CBT_F_N 3'h2
`define CBT_F_V 3'h3
`define CBT_F_S 3'h4
`define CBT_F_H 3'h5
`define CBT_F_T 3'h6
`define CBT_F_I 3'h7
// ***********************************
// last execute phase (cycles minus 1)
// ***********************************
`define CBT_LAST_ONE 2'h0
`define CBT_LAST_TWO 2'h1
`define CBT_LAST_PM  2'h2
`endif

// ==== pkg/cbt_pkg.sv ====
/*
 * types of the bit and transfer execution core
 * assumes nothing of its surroundings
 */
package cbt_pkg;
	// execute sequencer states
	typedef enum logic {cbt_idle, cbt_exec} cbt_state_t;
endpackage

// ==== design/cbt_core.sv ====
/*
 * bit, flag and data transfer execution core with 32 working
 * registers, status flags, stack pointer and a wishbone port.
 * assumes data memory and i/o answer reads combinationally,
 * program memory within two cycles, all on clk_i.
 */
// What this block does
// - io bit set, flags kept, two cycles
// - io bit clear, flags kept, two cycles
// - rotate left through carry, one cycle
// - rotate right through carry, one cycle
// - copy register bit into transfer flag
// - copy transfer flag into register bit
// - set or clear overflow flag alone
// - set or clear half carry alone
// - set or clear signed flag alone
// - indirect load then pointer plus one
// - pointer minus one then indirect load
// - load at pointer plus displacement
// - load from constant address, two cycles
// - indirect store then pointer plus one
// - pointer minus one then indirect store
// - store at pointer plus displacement
// - store to constant address, two cycles
// - program memory byte via z, three cycles
// - push register onto stack, two cycles
// - pop stack byte into register, two cycles
`timescale 1ns/1ps
`include "cbt_defs.svh"
module cbt_core (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic      [15:0] dm_adr_o,
	output logic             dm_re_o,
	output logic             dm_we_o,
	output logic      [7:0]  dm_dat_o,
	input  wire logic [7:0]  dm_dat_i,
	output logic      [7:0]  io_adr_o,
	output logic             io_re_o,
	output logic             io_we_o,
	output logic      [7:0]  io_dat_o,
	input  wire logic [7:0]  io_dat_i,
	output logic      [14:0] pm_adr_o,
	output logic             pm_re_o,
	input  wire logic [15:0] pm_dat_i,
	output logic             busy_o
);
	// ***********
	// declarations
	// ***********
	cbt_pkg::cbt_state_t state_reg;
	logic [7:0]  rf [32];
	logic [31:0] insn_reg;
	logic [1:0]  ph_reg;
	logic [7:0]  flags_reg;
	logic [15:0] sp_reg;
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic [15:0] dm_adr_reg;
	logic        dm_re_reg;
	logic        dm_we_reg;
	logic [7:0]  dm_dat_reg;
	logic [7:0]  io_dat_reg;
	logic        io_we_reg;
	logic [14:0] pm_adr_reg;
	logic        pm_re_reg;
	logic [5:0]  op;
	logic [4:0]  rd;
	logic [4:0]  rsrc;
	logic [15:0] imm;
	logic [2:0]  bsel;
	logic [4:0]  pidx;
	logic [15:0] ptr;
	logic [15:0] eff_adr;
	logic [7:0]  a;
	logic [7:0]  res;
	logic        cy;
	logic        busy;
	logic        last;
	logic        wr_now;
	logic        go;

	// ******************
	// decode helpers
	// ******************
	// last phase index of each instruction
	function automatic logic [1:0] op_last(input logic [5:0] o);
		unique case (o)
			`CBT_OP_IOS, `CBT_OP_IOC, `CBT_OP_LDX, `CBT_OP_STX,
			`CBT_OP_DRD, `CBT_OP_DWR, `CBT_OP_PUSH,
			`CBT_OP_POP: op_last = `CBT_LAST_TWO;
			`CBT_OP_CODE: op_last = `CBT_LAST_PM;
			default: op_last = `CBT_LAST_ONE;
		endcase
	endfunction

	// shift and rotate group
	function automatic logic is_shift(input logic [5:0] o);
		is_shift = (o >= `CBT_OP_SHUP) && (o <= `CBT_OP_SHSG);
	endfunction

	// instruction fields
	assign op   = insn_reg[31:26];
	assign rd   = insn_reg[25:21];
	assign rsrc = insn_reg[20:16];
	assign imm  = insn_reg[15:0];
	// i/o bit ops keep the bit index apart from the port address
	assign bsel = (op == `CBT_OP_IOS || op == `CBT_OP_IOC) ? rsrc[2:0]
		: imm[2:0];
	// program reads always use z, other transfers pick x, y, z or, for rsrc[1:0] of 3, r1:r0
	assign pidx = (op == `CBT_OP_CODE) ? `CBT_PTR_Z
		: `CBT_PTR_BASE + {2'h0, rsrc[1:0], 1'b0};
	assign ptr  = {rf[pidx + 5'h01], rf[pidx]};
	assign a    = rf[rd];
	assign busy = state_reg == cbt_pkg::cbt_exec;
	assign last = busy && ph_reg == op_last(op);
	assign busy_o = busy;

	// *****************
	// wishbone slave
	// *****************
	assign wr_now = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
	assign go = wr_now && !busy && wb_adr_i == `CBT_ADR_INSN
		&& (&wb_sel_i);
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// ack one cycle after the request, dropped the next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
	end

	// read data, unmapped offsets read zero
	always_ff @(posedge clk_i) begin
		if (rst_i)
			dat_reg <= 32'h0000_0000;
		else if (wb_adr_i >= `CBT_ADR_GPR)
			dat_reg <= {24'h00_0000, rf[wb_adr_i[6:2]]};
		else if (wb_adr_i == `CBT_ADR_INSN)
			dat_reg <= insn_reg;
		else if (wb_adr_i == `CBT_ADR_STAT)
			dat_reg <= {23'h00_0000, busy, flags_reg};
		else if (wb_adr_i == `CBT_ADR_SP)
			dat_reg <= {16'h0000, sp_reg};
		else
			dat_reg <= 32'h0000_0000;
	end

	// ******************
	// sequencer
	// ******************
	// accepts one instruction while idle, steps the phases
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= cbt_pkg::cbt_idle;
			ph_reg    <= 2'h0;
			insn_reg  <= 32'h0000_0000;
		end else if (go) begin
			state_reg <= cbt_pkg::cbt_exec;
			ph_reg    <= 2'h0;
			insn_reg  <= wb_dat_i;
		end else if (last) begin
			state_reg <= cbt_pkg::cbt_idle;
		end else if (busy) begin
			ph_reg <= ph_reg + 2'h1;
		end
	end

	// ******************
	// shifter and address
	// ******************
	// shift result and carry out of the shift group
	always_comb begin
		res = a;
		cy  = flags_reg[`CBT_F_C];
		unique case (op)
			`CBT_OP_SHUP: begin
				res = {a[6:0], 1'b0};
				cy  = a[7];
			end
			`CBT_OP_SHDN: begin
				res = {1'b0, a[7:1]};
				cy  = a[0];
			end
			`CBT_OP_ROTL: begin
				res = {a[6:0], flags_reg[`CBT_F_C]};
				cy  = a[7];
			end
			`CBT_OP_ROTR: begin
				res = {flags_reg[`CBT_F_C], a[7:1]};
				cy  = a[0];
			end
			`CBT_OP_SHSG: begin
				res = {a[7], a[7:1]};
				cy  = a[0];
			end
			`CBT_OP_SWAP: res = {a[3:0], a[7:4]};
			default: res = a;
		endcase
	end

	// data memory address of the current transfer
	always_comb begin
		eff_adr = ptr;
		unique case (op)
			`CBT_OP_LDX, `CBT_OP_STX: begin
				if (rsrc[3:2] == `CBT_PM_PRE)
					eff_adr = ptr - 16'h0001;
				else if (rsrc[3:2] == `CBT_PM_DISP)
					eff_adr = ptr + {10'h000, imm[5:0]};
				else
					eff_adr = ptr;
			end
			`CBT_OP_DRD, `CBT_OP_DWR: eff_adr = imm;
			`CBT_OP_PUSH: eff_adr = sp_reg;
			`CBT_OP_POP: eff_adr = sp_reg + 16'h0001;
			default: eff_adr = ptr;
		endcase
	end

	// ******************
	// memory ports
	// ******************
	// phase 0 loads address and strobes, last phase clears them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dm_adr_reg <= 16'h0000;
			dm_re_reg  <= 1'b0;
			dm_we_reg  <= 1'b0;
			dm_dat_reg <= 8'h00;
		end else if (busy && ph_reg == 2'h0 && !last) begin
			dm_adr_reg <= eff_adr;
			dm_re_reg  <= op == `CBT_OP_LDX || op == `CBT_OP_DRD
				|| op == `CBT_OP_POP;
			dm_we_reg  <= op == `CBT_OP_STX || op == `CBT_OP_DWR
				|| op == `CBT_OP_PUSH;
			dm_dat_reg <= a;
		end else if (last) begin
			dm_re_reg <= 1'b0;
			dm_we_reg <= 1'b0;
		end
	end

	assign dm_adr_o = dm_adr_reg;
	assign dm_re_o  = dm_re_reg;
	assign dm_we_o  = dm_we_reg;
	assign dm_dat_o = dm_dat_reg;

	// i/o read modify write and port out
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			io_dat_reg <= 8'h00;
			io_we_reg  <= 1'b0;
		end else if (busy && ph_reg == 2'h0 && op == `CBT_OP_IOS) begin
			io_dat_reg <= io_dat_i | (8'h01 << bsel);
			io_we_reg  <= 1'b1;
		end else if (busy && ph_reg == 2'h0 && op == `CBT_OP_IOC) begin
			io_dat_reg <= io_dat_i & ~(8'h01 << bsel);
			io_we_reg  <= 1'b1;
		end else if (last) begin
			io_we_reg <= 1'b0;
		end
	end

	assign io_adr_o = imm[7:0];
	assign io_re_o  = busy && ph_reg == 2'h0 && (op == `CBT_OP_IOS
		|| op == `CBT_OP_IOC || op == `CBT_OP_IN);
	assign io_we_o  = io_we_reg || (busy && op == `CBT_OP_OUT);
	assign io_dat_o = io_we_reg ? io_dat_reg : a;

	// program memory word address from z
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pm_adr_reg <= 15'h0000;
			pm_re_reg  <= 1'b0;
		end else if (busy && op == `CBT_OP_CODE && ph_reg == 2'h0) begin
			pm_adr_reg <= ptr[15:1];
			pm_re_reg  <= 1'b1;
		end else if (last) begin
			pm_re_reg <= 1'b0;
		end
	end

	assign pm_adr_o = pm_adr_reg;
	assign pm_re_o  = pm_re_reg;

	// ******************
	// working registers
	// ******************
	// one write set per cycle, pointer writes after results
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 32; i++)
				rf[i] <= 8'h00;
		end else if (!busy && wr_now && wb_adr_i >= `CBT_ADR_GPR
			&& wb_sel_i[0]) begin
			rf[wb_adr_i[6:2]] <= wb_dat_i[7:0];
		end else if (busy) begin
			unique case (op)
				`CBT_OP_SHUP, `CBT_OP_SHDN, `CBT_OP_ROTL, `CBT_OP_ROTR,
				`CBT_OP_SHSG, `CBT_OP_SWAP: rf[rd] <= res;
				`CBT_OP_TPUT: rf[rd][bsel] <= flags_reg[`CBT_F_T];
				`CBT_OP_COPY: rf[rd] <= rf[rsrc];
				`CBT_OP_CPYW: begin
					rf[{rd[4:1], 1'b0}] <= rf[{rsrc[4:1], 1'b0}];
					rf[{rd[4:1], 1'b1}] <= rf[{rsrc[4:1], 1'b1}];
				end
				`CBT_OP_IMM: rf[rd] <= imm[7:0];
				`CBT_OP_IN: rf[rd] <= io_dat_i;
				`CBT_OP_LDX, `CBT_OP_STX: begin
					if (last && op == `CBT_OP_LDX)
						rf[rd] <= dm_dat_i;
					if (ph_reg == 2'h0 && rsrc[3:2] == `CBT_PM_PRE)
						{rf[pidx + 5'h01], rf[pidx]} <= eff_adr;
					if (last && rsrc[3:2] == `CBT_PM_POST)
						{rf[pidx + 5'h01], rf[pidx]} <=
							ptr + 16'h0001;
				end
				`CBT_OP_DRD, `CBT_OP_POP: begin
					if (last)
						rf[rd] <= dm_dat_i;
				end
				`CBT_OP_CODE: begin
					if (last) begin
						rf[rd] <= ptr[0] ? pm_dat_i[15:8]
							: pm_dat_i[7:0];
						if (rsrc[0])
							{rf[5'h1f], rf[5'h1e]} <= ptr + 16'h0001;
					end
				end
				default: rf[rd] <= rf[rd];
			endcase
		end
	end

	// ******************
	// stack pointer
	// ******************
	// push stores then decrements, pop increments then loads
	always_ff @(posedge clk_i) begin
		if (rst_i)
			sp_reg <= `CBT_SP_RST;
		else if (!busy && wr_now && wb_adr_i == `CBT_ADR_SP
			&& (&wb_sel_i[1:0]))
			sp_reg <= wb_dat_i[15:0];
		else if (last && op == `CBT_OP_PUSH)
			sp_reg <= sp_reg - 16'h0001;
		else if (busy && ph_reg == 2'h0 && op == `CBT_OP_POP)
			sp_reg <= eff_adr;
	end

	// ******************
	// status flags
	// ******************
	// only status writes, the shift group, flag set and clear, and TCAP change flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_reg <= 8'h00;
		end else if (!busy && wr_now && wb_adr_i == `CBT_ADR_STAT
			&& wb_sel_i[0]) begin
			flags_reg <= wb_dat_i[7:0];
		end else if (busy && is_shift(op)) begin
			flags_reg[`CBT_F_C] <= cy;
			flags_reg[`CBT_F_Z] <= res == 8'h00;
			flags_reg[`CBT_F_N] <= res[7];
			flags_reg[`CBT_F_V] <= res[7] ^ cy;
		end else if (busy && op == `CBT_OP_FSET) begin
			flags_reg[bsel] <= 1'b1;
		end else if (busy && op == `CBT_OP_FCLR) begin
			flags_reg[bsel] <= 1'b0;
		end else if (busy && op == `CBT_OP_TCAP) begin
			flags_reg[`CBT_F_T] <= rf[rsrc][bsel];
		end
	end

	// ******************
	// assertions
	// ******************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_io_set;
		go && wb_dat_i[31:26] == `CBT_OP_IOS |=> io_re_o ##1
			(io_we_o && io_dat_o[bsel] && $stable(flags_reg))
			##1 !busy;
	endproperty
	a_io_set: assert property (p_io_set)
		else $error("io bit set wrong");

	property p_io_clr;
		go && wb_dat_i[31:26] == `CBT_OP_IOC |=> ##1
			(io_we_o && !io_dat_o[bsel]) ##1 !busy;
	endproperty
	a_io_clr: assert property (p_io_clr)
		else $error("io bit clear wrong");

	property p_rotl;
		busy && op == `CBT_OP_ROTL |=> !busy
			&& rf[rd] == {$past(a[6:0]), $past(flags_reg[0])}
			&& flags_reg[0] == $past(a[7]);
	endproperty
	a_rotl: assert property (p_rotl)
		else $error("rotate left wrong");

	property p_rotr;
		busy && op == `CBT_OP_ROTR |=>
			rf[rd] == {$past(flags_reg[0]), $past(a[7:1])}
			&& flags_reg[0] == $past(a[0]);
	endproperty
	a_rotr: assert property (p_rotr)
		else $error("rotate right wrong");

	property p_tcap;
		busy && op == `CBT_OP_TCAP |=> flags_reg[6] == $past(rf[rsrc][bsel])
			&& flags_reg[5:0] == $past(flags_reg[5:0]);
	endproperty
	a_tcap: assert property (p_tcap)
		else $error("bit store wrong");

	property p_tput;
		busy && op == `CBT_OP_TPUT |=> rf[rd][bsel] == flags_reg[6]
			&& $stable(flags_reg);
	endproperty
	a_tput: assert property (p_tput)
		else $error("bit load wrong");

	property p_fset;
		busy && op == `CBT_OP_FSET |=> flags_reg ==
			($past(flags_reg) | (8'h01 << $past(bsel)));
	endproperty
	a_fset: assert property (p_fset)
		else $error("flag set touched other flags");

	property p_rd_post;
		go && wb_dat_i[31:26] == `CBT_OP_LDX
			&& wb_dat_i[19:18] == `CBT_PM_POST
		|=> ##1 (dm_re_o && dm_adr_o == $past(ptr)) ##1
			(!busy && ptr == $past(dm_adr_o) + 16'h0001);
	endproperty
	a_rd_post: assert property (p_rd_post)
		else $error("post increment load wrong");

	property p_wr_pre;
		busy && ph_reg == 2'h0 && op == `CBT_OP_STX
			&& rsrc[3:2] == `CBT_PM_PRE
		|=> dm_we_o && dm_adr_o == ptr && dm_adr_o == $past(ptr) - 16'h0001;
	endproperty
	a_wr_pre: assert property (p_wr_pre)
		else $error("pre decrement store wrong");

	property p_dwr;
		go && wb_dat_i[31:26] == `CBT_OP_DWR |=> ##1
			(dm_we_o && dm_adr_o == imm) ##1 (!busy && !dm_we_o);
	endproperty
	a_dwr: assert property (p_dwr)
		else $error("direct store wrong");

	property p_code;
		go && wb_dat_i[31:26] == `CBT_OP_CODE |=> busy[*3] ##1 !busy;
	endproperty
	a_code: assert property (p_code)
		else $error("program read not three cycles");

	property p_push;
		busy && ph_reg == 2'h1 && op == `CBT_OP_PUSH |->
			dm_we_o && dm_adr_o == sp_reg ##1 sp_reg == $past(sp_reg) - 16'h0001;
	endproperty
	a_push: assert property (p_push)
		else $error("push wrong");

	property p_one;
		go && wb_dat_i[31:26] == `CBT_OP_COPY |=> busy ##1
			(!busy && $stable(flags_reg));
	endproperty
	a_one: assert property (p_one)
		else $error("move not one cycle");
endmodule

// ==== tb/cbt_mem_model.sv ====
/*
 * memory side model: data memory, i/o space and program memory
 * assumes the core strobes reads and writes on rising clk_i
 */
`timescale 1ns/1ps
module cbt_mem_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] dm_adr_i,
	input  wire logic        dm_re_i,
	input  wire logic        dm_we_i,
	input  wire logic [7:0]  dm_dat_i,
	output logic      [7:0]  dm_dat_o,
	input  wire logic [7:0]  io_adr_i,
	input  wire logic        io_re_i,
	input  wire logic        io_we_i,
	input  wire logic [7:0]  io_dat_i,
	output logic      [7:0]  io_dat_o,
	input  wire logic [14:0] pm_adr_i,
	input  wire logic        pm_re_i,
	output logic      [15:0] pm_dat_o
);
	logic [7:0]  dm [256];
	logic [7:0]  io [256];
	logic [15:0] pm [128];
	// answer at once; unstrobed lines show the inverted byte
	assign dm_dat_o = dm_re_i ? dm[dm_adr_i[7:0]] : ~dm[dm_adr_i[7:0]];
	assign io_dat_o = io_re_i ? io[io_adr_i] : ~io[io_adr_i];
	assign pm_dat_o = pm_re_i ? pm[pm_adr_i[6:0]] : ~pm[pm_adr_i[6:0]];
	// writes land at the strobed edge
	always @(posedge clk_i) begin
		if (dm_we_i)
			dm[dm_adr_i[7:0]] <= dm_dat_i;
		if (io_we_i)
			io[io_adr_i] <= io_dat_i;
	end
endmodule

// ==== tb/cbt_core_tb.sv ====
/*
 * self-checking bench of the bit and transfer core
 * assumes the memory model answers on the core's far side
 */
`timescale 1ns/1ps
module cbt_core_tb;
	logic        clk_i, rst_i, cyc, stb, we, ack;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	logic [15:0] dm_adr, pm_dat;
	logic [14:0] pm_adr;
	logic [7:0]  dm_wd, dm_rd, io_adr, io_wd, io_rd;
	logic        dm_re, dm_we, io_re, io_we, pm_re, busy_o;
	int          error_cnt, n_tests, cyc_cnt;
	logic [31:0] v;
	// ********
	// ordinary cases: insn, reg in, flags in, reg out, flags out
	// ********
	localparam logic [63:0] ROWS [12] = '{
		64'h14200000_80_01_01_09, 64'h18400000_01_00_00_0b,
		64'h18400000_02_01_81_0c, 64'h0c600000_81_e0_02_e9,
		64'h10800000_81_10_40_19, 64'h1ca00000_81_00_c0_05,
		64'h20c00000_3c_5a_c3_5a, 64'h2ce70003_08_00_08_40,
		64'h31080007_00_40_80_40, 64'h3d2000a5_00_3f_a5_3f,
		64'h01400000_77_a5_77_a5, 64'h356b0000_5e_c3_5e_c3};
	cbt_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.dm_adr_o(dm_adr), .dm_re_o(dm_re), .dm_we_o(dm_we),
		.dm_dat_o(dm_wd), .dm_dat_i(dm_rd), .io_adr_o(io_adr),
		.io_re_o(io_re), .io_we_o(io_we), .io_dat_o(io_wd),
		.io_dat_i(io_rd), .pm_adr_o(pm_adr), .pm_re_o(pm_re),
		.pm_dat_i(pm_dat), .busy_o(busy_o));
	cbt_mem_model i_mem (.clk_i(clk_i), .dm_adr_i(dm_adr),
		.dm_re_i(dm_re), .dm_we_i(dm_we), .dm_dat_i(dm_wd),
		.dm_dat_o(dm_rd), .io_adr_i(io_adr), .io_re_i(io_re),
		.io_we_i(io_we), .io_dat_i(io_wd), .io_dat_o(io_rd),
		.pm_adr_i(pm_adr), .pm_re_i(pm_re), .pm_dat_o(pm_dat));
	// clock at 5 ns
	initial begin
		clk_i = 0;
		forever #2.5 clk_i = ~clk_i;
	end
	// hang guard
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			test_done();
		end
	end
	task test_done();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one classic bus cycle, held until ack is sampled
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		v = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask
	task setr(input int n, input logic [7:0] d);
		bus(1, 8'(8'h80 + n * 4), {24'h0, d});
	endtask
	task ckr(input int n, input logic [7:0] e);
		bus(0, 8'(8'h80 + n * 4), 0);
		chk(v, {24'h0, e});
	endtask
	task ckf(input logic [7:0] e);
		bus(0, 8'h04, 0);
		chk(v, {24'h0, e});
	endtask
	// start an instruction and count its busy cycles
	task ex(input logic [31:0] w, input int c);
		int n;
		n = 0;
		bus(1, 8'h00, w);
		// the word lands at the edge bus returns on; busy rises there
		#1;
		while (busy_o === 1'b1 && n < 40) begin
			n++;
			@(posedge clk_i);
			#1;
		end
		chk(32'(n), 32'(c));
	endtask
	// ********
	// main sequence
	// ********
	initial begin
		{cyc, stb, we, adr, sel, wdat} = '0;
		rst_i = 1;
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		ckf(8'h00);
		bus(0, 8'h08, 0);
		chk(v, 32'h00ff);
		ckr(0, 8'h00);
		bus(1, 8'h40, 32'hff);
		bus(0, 8'h40, 0);
		chk(v, 0);
		$display("done: reset");
		foreach (ROWS[i]) begin
			setr(ROWS[i][57:53], ROWS[i][31:24]);
			bus(1, 8'h04, {24'h0, ROWS[i][23:16]});
			ex(ROWS[i][63:32], 1);
			ckr(ROWS[i][57:53], ROWS[i][15:8]);
			bus(0, 8'h04, 0);
			chk(v, {24'h0, ROWS[i][7:0]});
		end
		$display("done: rows");
		for (int i = 0; i < 8; i++) begin
			bus(1, 8'h04, 0);
			ex(32'h24000000 | i, 1);
			ckf(8'(1 << i));
			bus(1, 8'h04, 32'hff);
			ex(32'h28000000 | i, 1);
			ckf(~8'(1 << i));
		end
		$display("done: flags");
		setr(26, 8'h20);
		setr(27, 0);
		i_mem.dm[8'h20] = 8'h5b;
		ex(32'h40240000, 2);
		ckr(1, 8'h5b);
		ckr(26, 8'h21);
		setr(28, 8'h31);
		setr(29, 0);
		i_mem.dm[8'h30] = 8'h6c;
		ex(32'h40490000, 2);
		ckr(2, 8'h6c);
		ckr(28, 8'h30);
		setr(30, 8'h40);
		setr(31, 0);
		i_mem.dm[8'h45] = 8'h7d;
		ex(32'h406e0005, 2);
		ckr(3, 8'h7d);
		ckr(30, 8'h40);
		i_mem.dm[8'h50] = 8'h8e;
		ex(32'h48800050, 2);
		ckr(4, 8'h8e);
		$display("done: loads");
		setr(5, 8'h9f);
		setr(30, 8'h60);
		ex(32'h44a60000, 2);
		chk(i_mem.dm[8'h60], 8'h9f);
		ckr(30, 8'h61);
		setr(6, 8'ha1);
		setr(26, 8'h70);
		ex(32'h44c80000, 2);
		chk(i_mem.dm[8'h6f], 8'ha1);
		ckr(26, 8'h6f);
		setr(7, 8'hb2);
		setr(28, 8'h10);
		ex(32'h44ed0002, 2);
		chk(i_mem.dm[8'h12], 8'hb2);
		ckr(28, 8'h10);
		setr(8, 8'hc3);
		ex(32'h4d000080, 2);
		chk(i_mem.dm[8'h80], 8'hc3);
		bus(1, 8'h04, 32'h5a);
		ex(32'h5d000000, 2);
		chk(i_mem.dm[8'hff], 8'hc3);
		ex(32'h61200000, 2);
		ckr(9, 8'hc3);
		bus(0, 8'h08, 0);
		chk(v, 32'h00ff);
		ckf(8'h5a);
		$display("done: stores and stack");
		setr(30, 8'h21);
		i_mem.pm[16] = 16'hd4e5;
		i_mem.pm[17] = 16'h0a0b;
		ex(32'h51410000, 3);
		ckr(10, 8'hd4);
		ex(32'h51600000, 3);
		ckr(11, 8'h0b);
		ckr(30, 8'h22);
		i_mem.io[8'h15] = 8'h00;
		ex(32'h04050015, 2);
		chk(i_mem.io[8'h15], 8'h20);
		i_mem.io[8'h15] = 8'hff;
		ex(32'h08050015, 2);
		chk(i_mem.io[8'h15], 8'hdf);
		ckf(8'h5a);
		setr(12, 8'he6);
		ex(32'h598c0033, 1);
		chk(i_mem.io[8'h33], 8'he6);
		ex(32'h55ad0033, 1);
		ckr(13, 8'he6);
		setr(16, 8'h11);
		setr(17, 8'h22);
		ex(32'h39d00000, 1);
		ckr(14, 8'h11);
		ckr(15, 8'h22);
		$display("done: program memory and ports");
		test_done();
	end
endmodule
